// [verilog/core_sfr_map.svh]
// special register offsets, field positions, reset values
// assumes an 8-bit special register address space
`ifndef CORE_SFR_MAP_SVH
`define CORE_SFR_MAP_SVH
`define ADDR_STACK_POINTER 8'h81
`define ADDR_DPTR_LOW 8'h82
`define ADDR_DPTR_HIGH 8'h83
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_AUX_CONTROL 8'ha2
`define ADDR_STATUS_WORD 8'hd0
`define ADDR_WORKING_REG 8'he0
`define ADDR_MUL_DIV_EXT 8'hf0
`define RST_STACK_POINTER 8'h07
`define RST_ZERO_BYTE 8'h00
`define BIT_CARRY 7
`define BIT_HALF_CARRY 6
`define BIT_USER_ZERO 5
`define BIT_BANK_HI 4
`define BIT_BANK_LO 3
`define BIT_SIGN_WRAP 2
`define BIT_USER_ONE 1
`define BIT_PARITY 0
`define BIT_SLEEP_REQ 1
`define BIT_PTR_CHOICE 0
`endif

// [verilog/core_sfr_pkg.sv]
// types shared by the special register block
// assumes the map header carries all numbers
package core_sfr_pkg;
    // stack operation requested by the datapath
    typedef enum logic [1:0]
    {
        STK_NONE,
        STK_PUSH,
        STK_POP
    } stack_op_t;
    // arithmetic result write
    typedef enum logic [1:0]
    {
        ARITH_NONE,
        ARITH_MUL,
        ARITH_DIV
    } arith_op_t;
endpackage

// [verilog/dptr_store.sv]
// two copies of the 16-bit data pointer, one selected at a time
// assumes writes come from the register block on the same clock
`timescale 1ns/100ps
module dptr_store
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sel, // copy choice
    input wire logic wr_low, // write low byte
    input wire logic wr_high, // write high byte
    input wire logic wr_word, // write full 16 bits
    input wire logic [7:0] wdata, // byte write data
    input wire logic [15:0] wword, // word write data
    output logic [15:0] rword // selected copy, combinational view
);
    logic [15:0] copy_r [2]; // two physical pointers
    genvar g;
    // one generate slot per copy; only the chosen copy takes writes
    generate
        for (g = 0; g < 2; g++)
        begin : gen_copy
            wire logic hit = (sel == 1'(g));
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                    copy_r[g] <= 16'h0000;
                else if (hit && wr_word)
                    copy_r[g] <= wword;
                else if (hit && wr_high)
                    copy_r[g][15:8] <= wdata;
                else if (hit && wr_low)
                    copy_r[g][7:0] <= wdata;
            end
        end
    endgenerate
    // combinational view of the selected copy; no read latency
    assign rword = sel ? copy_r[1] : copy_r[0];
endmodule

// [verilog/core_sfr.sv]
// What this block does
// - multiply puts high byte in extension
// - divide: remainder to extension, quotient working
// - extension is plain storage, resets zero
// - status word bits 7:1 read/write, parity bit read-only, reset zero
// - parity follows odd ones in working
// - two-bit selector picks one of four banks
// - push increments pointer before writing
// - pop reads then decrements pointer
// - stack pointer resets to 0x07
// - data pointer as word or bytes
// - two pointer copies, choice bit selects
// - auxiliary upper bits read zero
// - sleep request set by software, hardware clears
// - bank base selects register address
// - unmapped writes ignored, reads zero
// the core special registers; the datapath drives the ports below
`timescale 1ns/100ps
`include "core_sfr_map.svh"
module core_sfr
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire core_sfr_pkg::arith_op_t arith_op,
    input wire logic [15:0] arith_result,
    input wire logic flag_upd,
    input wire logic [3:0] flag_val,
    input wire logic working_wr,
    input wire logic [7:0] working_wdata,
    input wire core_sfr_pkg::stack_op_t stack_op,
    input wire logic dptr_word_wr,
    input wire logic [15:0] dptr_word,
    input wire logic ext_irq_wake,
    input wire logic [2:0] reg_index,
    output logic [4:0] bank_reg_addr,
    output logic [7:0] stack_addr,
    output logic [7:0] working_register,
    output logic [7:0] mul_div_extension,
    output logic [15:0] data_pointer,
    output logic sleep_request,
    output logic [7:0] status_word
);
    // state held across cycles, each but the pointer choice with its next value
    logic [7:0] ext_r, ext_nxt; // extension register
    logic [7:0] acc_r, acc_nxt; // working register
    logic [7:0] sp_r, sp_nxt; // stack pointer
    logic [6:0] flags_r, flags_nxt; // status bits 7:1
    logic sleep_r, sleep_nxt; // sleep request
    logic choice_r; // pointer choice
    wire logic parity; // live parity
    wire logic [7:0] psw_view; // status word as read
    wire logic [15:0] dptr_view; // selected pointer copy
    // register strobes
    wire logic wr_sp = sfr_wr && sfr_addr == `ADDR_STACK_POINTER;
    wire logic wr_dl = sfr_wr && sfr_addr == `ADDR_DPTR_LOW;
    wire logic wr_dh = sfr_wr && sfr_addr == `ADDR_DPTR_HIGH;
    wire logic wr_pc = sfr_wr && sfr_addr == `ADDR_POWER_CONTROL;
    wire logic wr_ax = sfr_wr && sfr_addr == `ADDR_AUX_CONTROL;
    wire logic wr_ps = sfr_wr && sfr_addr == `ADDR_STATUS_WORD;
    wire logic wr_ac = sfr_wr && sfr_addr == `ADDR_WORKING_REG;
    wire logic wr_b = sfr_wr && sfr_addr == `ADDR_MUL_DIV_EXT;

    // parity is computed, never stored, so it cannot go stale
    assign parity = ^acc_r;
    assign psw_view = {flags_r, parity};

    // bank base plus register index
    assign bank_reg_addr = {flags_r[`BIT_BANK_HI - 1:`BIT_BANK_LO - 1],
                            reg_index};

    // arithmetic outranks a plain write to the same register
    always_comb
    begin
        ext_nxt = ext_r;
        acc_nxt = acc_r;
        if (arith_op == core_sfr_pkg::ARITH_MUL ||
            arith_op == core_sfr_pkg::ARITH_DIV)
        begin
            // high byte / remainder to extension
            ext_nxt = arith_result[15:8];
            acc_nxt = arith_result[7:0];
        end
        else
        begin
            // no arithmetic result this cycle: plain writes apply
            if (wr_b)
                ext_nxt = sfr_wdata;
            // a register-bus write beats the datapath write
            if (wr_ac)
                acc_nxt = sfr_wdata;
            else if (working_wr)
                acc_nxt = working_wdata;
        end
    end

    // status flags: explicit write first, then flag update
    always_comb
    begin
        flags_nxt = flags_r;
        if (wr_ps)
            flags_nxt = sfr_wdata[7:1];
        else if (flag_upd)
        begin
            // carry, half carry, sign wrap from datapath
            flags_nxt[`BIT_CARRY - 1] = flag_val[3];
            flags_nxt[`BIT_HALF_CARRY - 1] = flag_val[2];
            flags_nxt[`BIT_SIGN_WRAP - 1] = flag_val[1];
        end
    end

    // stack pointer: increment on push, decrement on pop
    always_comb
    begin
        sp_nxt = sp_r;
        stack_addr = sp_r; // pop address is current value
        case (stack_op)
            core_sfr_pkg::STK_PUSH:
            begin
                sp_nxt = sp_r + 8'h01;
                stack_addr = sp_r + 8'h01;
            end
            core_sfr_pkg::STK_POP:
                sp_nxt = sp_r - 8'h01;
            // plain pointer write only while the stack is idle
            core_sfr_pkg::STK_NONE:
                if (wr_sp)
                    sp_nxt = sfr_wdata;
            default:
                sp_nxt = sp_r;
        endcase
    end

    // wake wins over a simultaneous software set
    always_comb
    begin
        sleep_nxt = sleep_r;
        if (wr_pc)
            sleep_nxt = sfr_wdata[`BIT_SLEEP_REQ];
        // an enabled external interrupt ends the request
        if (ext_irq_wake)
            sleep_nxt = 1'b0;
    end

    // state registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ext_r <= `RST_ZERO_BYTE;
            acc_r <= `RST_ZERO_BYTE;
            sp_r <= `RST_STACK_POINTER;
            flags_r <= 7'h00;
            sleep_r <= 1'b0;
            choice_r <= 1'b0;
        end
        else
        begin
            ext_r <= ext_nxt;
            acc_r <= acc_nxt;
            sp_r <= sp_nxt;
            flags_r <= flags_nxt;
            sleep_r <= sleep_nxt;
            // only the choice bit is stored; bits 7:1 read zero
            if (wr_ax)
                choice_r <= sfr_wdata[`BIT_PTR_CHOICE];
        end
    end

    // the pointer copies live in their own store
    dptr_store u_dptr
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .sel(choice_r),
        .wr_low(wr_dl),
        .wr_high(wr_dh),
        .wr_word(dptr_word_wr),
        .wdata(sfr_wdata),
        .wword(dptr_word),
        .rword(dptr_view)
    );

    // read mux; unmapped addresses return zero
    always_comb
    begin
        case (sfr_addr)
            `ADDR_STACK_POINTER: sfr_rdata = sp_r;
            `ADDR_DPTR_LOW: sfr_rdata = dptr_view[7:0];
            `ADDR_DPTR_HIGH: sfr_rdata = dptr_view[15:8];
            `ADDR_POWER_CONTROL:
                sfr_rdata = {6'h00, sleep_r, 1'b0};
            `ADDR_AUX_CONTROL: sfr_rdata = {7'h00, choice_r};
            `ADDR_STATUS_WORD: sfr_rdata = psw_view;
            `ADDR_WORKING_REG: sfr_rdata = acc_r;
            `ADDR_MUL_DIV_EXT: sfr_rdata = ext_r;
            default: sfr_rdata = 8'h00;
        endcase
    end

    // outputs depend on the registers alone, with no path from the inputs
    assign working_register = acc_r;
    assign mul_div_extension = ext_r;
    assign data_pointer = dptr_view;
    assign sleep_request = sleep_r;
    assign status_word = psw_view;

    // assertions
    // push: the pointer moves up first, the byte goes to the new slot
    sequence s_push;
        stack_op == core_sfr_pkg::STK_PUSH;
    endsequence
    // pop: the byte is read at the current slot, then the pointer drops
    sequence s_pop;
        stack_op == core_sfr_pkg::STK_POP;
    endsequence
    // extension write with no arithmetic result claiming the register
    sequence s_ext_write;
        wr_b && arith_op == core_sfr_pkg::ARITH_NONE;
    endsequence
    // software asks for sleep while no wake is pending
    sequence s_sleep_set;
        wr_pc && sfr_wdata[`BIT_SLEEP_REQ] && !ext_irq_wake;
    endsequence
    a_parity_live: assert property (
        @(posedge sys_clk) disable iff (rst)
        status_word[0] == ^working_register)
        else $error("parity flag wrong");
    a_push_incr: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_push |=> sp_r == $past(sp_r) + 8'h01)
        else $error("push did not increment");
    a_push_addr: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_push |-> stack_addr == sp_r + 8'h01)
        else $error("push address wrong");
    a_pop_decr: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_pop |-> stack_addr == sp_r
        ##1 sp_r == $past(sp_r) - 8'h01)
        else $error("pop order wrong");
    a_mul_result: assert property (
        @(posedge sys_clk) disable iff (rst)
        arith_op == core_sfr_pkg::ARITH_MUL |=>
        {ext_r, acc_r} == $past(arith_result))
        else $error("multiply result misplaced");
    a_div_result: assert property (
        @(posedge sys_clk) disable iff (rst)
        arith_op == core_sfr_pkg::ARITH_DIV |=>
        ext_r == $past(arith_result[15:8]))
        else $error("remainder misplaced");
    // the quotient lands in the working register
    a_div_quot: assert property (
        @(posedge sys_clk) disable iff (rst)
        arith_op == core_sfr_pkg::ARITH_DIV |=>
        acc_r == $past(arith_result[7:0]))
        else $error("quotient misplaced");
    // outside arithmetic the extension is plain storage
    a_ext_store: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_ext_write |=> ext_r == $past(sfr_wdata))
        else $error("extension write lost");
    // a lone flag update reaches carry, half carry and sign wrap
    a_flag_update: assert property (
        @(posedge sys_clk) disable iff (rst)
        flag_upd && !wr_ps |=>
        status_word[`BIT_CARRY] == $past(flag_val[3]) &&
        status_word[`BIT_HALF_CARRY] == $past(flag_val[2]) &&
        status_word[`BIT_SIGN_WRAP] == $past(flag_val[1]))
        else $error("flag update lost");
    // a status write moves the bank base on the next cycle
    a_bank_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_ps |=> bank_reg_addr[4:3] ==
        $past(sfr_wdata[`BIT_BANK_HI:`BIT_BANK_LO]))
        else $error("bank base not updated");
    // a word write shows through while the choice holds
    a_word_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        dptr_word_wr && !wr_ax |=> data_pointer == $past(dptr_word))
        else $error("pointer word write lost");
    // the choice bit follows the auxiliary write
    a_choice_bit: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_ax |=> choice_r == $past(sfr_wdata[`BIT_PTR_CHOICE]))
        else $error("pointer choice not stored");
    a_wake_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        ext_irq_wake |=> !sleep_request)
        else $error("sleep not cleared");
    // software raises the request when no wake contends
    a_sleep_set: assert property (
        @(posedge sys_clk) disable iff (rst)
        s_sleep_set |=> sleep_request)
        else $error("sleep request not set");
    a_unmapped_zero: assert property (
        @(posedge sys_clk) disable iff (rst)
        sfr_addr == 8'h80 |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    // power control shows only the sleep request bit
    a_power_rsvd: assert property (
        @(posedge sys_clk) disable iff (rst)
        sfr_addr == `ADDR_POWER_CONTROL |->
        sfr_rdata[7:2] == 6'h00 && sfr_rdata[0] == 1'b0)
        else $error("power reserved bits set");
    a_write_wins: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_ps && flag_upd |=> flags_r == $past(sfr_wdata[7:1]))
        else $error("flag update beat write");
    a_aux_upper: assert property (
        @(posedge sys_clk) disable iff (rst)
        sfr_addr == `ADDR_AUX_CONTROL |-> sfr_rdata[7:1] == 7'h00)
        else $error("aux reserved bits set");
endmodule

// [bench/dp_model.sv]
// datapath stand-in: forms mul/div results from the live registers
// assumes the bench raises one go line for one cycle at a time
`timescale 1ns/100ps
module dp_model
(
    input wire logic mul_go,
    input wire logic div_go,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] ext_in,
    output core_sfr_pkg::arith_op_t arith_op,
    output logic [15:0] arith_result
);
    // divisor kept nonzero by the bench; a zero divisor gives zero quotient and remainder
    wire [7:0] quot = acc_in == 8'h00 ? 8'h00 : ext_in / acc_in;
    wire [7:0] remd = acc_in == 8'h00 ? 8'h00 : ext_in % acc_in;
    // product or {remainder, quotient}, as the core expects
    assign arith_op = mul_go ? core_sfr_pkg::ARITH_MUL :
        div_go ? core_sfr_pkg::ARITH_DIV : core_sfr_pkg::ARITH_NONE;
    assign arith_result = mul_go ? ext_in * acc_in : {remd, quot};
endmodule

// [bench/tb.sv]
// self-checking bench for the core special registers
// assumes inputs change on falling edges, checks after settling
`timescale 1ns/100ps
module tb;
    logic sys_clk = 0, rst = 1, sfr_wr = 0, flag_upd = 0;
    logic working_wr = 0, dptr_word_wr = 0, ext_irq_wake = 0;
    logic mul_go = 0, div_go = 0, sleep_request;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic [7:0] working_wdata = 8'h00, sfr_rdata, stack_addr;
    logic [7:0] working_register, mul_div_extension, status_word;
    logic [3:0] flag_val = 4'h0;
    logic [2:0] reg_index = 3'h0;
    logic [4:0] bank_reg_addr;
    logic [15:0] dptr_word = 16'h0000, arith_result, data_pointer;
    core_sfr_pkg::stack_op_t stack_op = core_sfr_pkg::STK_NONE;
    core_sfr_pkg::arith_op_t arith_op;
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    // 25 ns period
    always #12.5 sys_clk = ~sys_clk;
    core_sfr dut (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
        .sfr_rdata, .arith_op, .arith_result, .flag_upd, .flag_val,
        .working_wr, .working_wdata, .stack_op, .dptr_word_wr,
        .dptr_word, .ext_irq_wake, .reg_index, .bank_reg_addr,
        .stack_addr, .working_register, .mul_div_extension,
        .data_pointer, .sleep_request, .status_word);
    dp_model partner (.mul_go, .div_go, .acc_in(working_register),
        .ext_in(mul_div_extension), .arith_op, .arith_result);
    task stop_test;
        if (n_mismatch == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard, well above the run length
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            stop_test;
        end
    end
    task chk(input string nm, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle register write
    task wr(input logic [7:0] a, d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1;
        @(negedge sys_clk);
        sfr_wr = 0;
    endtask
    // combinational read, sampled once settled
    task rd(input logic [7:0] a, e);
        @(negedge sys_clk);
        sfr_addr = a;
        #1 chk("rdata", 16'(sfr_rdata), 16'(e));
    endtask
    task wk(input logic [7:0] d);
        @(negedge sys_clk);
        working_wdata = d;
        working_wr = 1;
        @(negedge sys_clk);
        working_wr = 0;
    endtask
    task t_reset;
        rd(8'h81, 8'h07);
        rd(8'h82, 8'h00);
        rd(8'h83, 8'h00);
        rd(8'h87, 8'h00);
        rd(8'ha2, 8'h00);
        rd(8'hd0, 8'h00);
        rd(8'hf0, 8'h00);
        chk("bank", 16'(bank_reg_addr), 16'h0000);
    endtask
    task t_arith;
        wr(8'hf0, 8'h0d);
        rd(8'hf0, 8'h0d);
        wk(8'h0c);
        @(negedge sys_clk);
        mul_go = 1;
        @(negedge sys_clk);
        mul_go = 0;
        chk("mul hi", 16'(mul_div_extension), 16'h0000);
        chk("mul lo", 16'(working_register), 16'h009c);
        wr(8'hf0, 8'h64);
        wk(8'h07);
        @(negedge sys_clk);
        div_go = 1;
        @(negedge sys_clk);
        div_go = 0;
        chk("div rem", 16'(mul_div_extension), 16'h0002);
        chk("div quo", 16'(working_register), 16'h000e);
    endtask
    task t_psw;
        wr(8'he0, 8'h0b);
        rd(8'hd0, 8'h01);
        wk(8'h07);
        chk("par odd", 16'(status_word[0]), 16'h0001);
        wk(8'h06);
        reg_index = 3'd5;
        // every bank encoding
        for (int b = 0; b < 4; b++)
        begin
            wr(8'hd0, 8'(b << 3));
            rd(8'hd0, 8'(b << 3));
            chk("bank", 16'(bank_reg_addr), 16'(b * 8 + 5));
        end
        // explicit write and flag update on the same edge
        @(negedge sys_clk);
        flag_val = 4'he;
        flag_upd = 1;
        sfr_addr = 8'hd0;
        sfr_wdata = 8'h22;
        sfr_wr = 1;
        @(negedge sys_clk);
        flag_upd = 0;
        sfr_wr = 0;
        rd(8'hd0, 8'h22);
        @(negedge sys_clk);
        flag_upd = 1;
        @(negedge sys_clk);
        flag_upd = 0;
        rd(8'hd0, 8'he6);
        wr(8'hd0, 8'h00);
    endtask
    task t_stack;
        @(negedge sys_clk);
        stack_op = core_sfr_pkg::STK_PUSH;
        #1 chk("push addr", 16'(stack_addr), 16'h0008);
        @(negedge sys_clk);
        stack_op = core_sfr_pkg::STK_POP;
        #1 chk("pop addr", 16'(stack_addr), 16'h0008);
        @(negedge sys_clk);
        stack_op = core_sfr_pkg::STK_NONE;
        rd(8'h81, 8'h07);
        wr(8'h81, 8'h20);
        rd(8'h81, 8'h20);
        @(negedge sys_clk);
        stack_op = core_sfr_pkg::STK_PUSH;
        #1 chk("push addr", 16'(stack_addr), 16'h0021);
        @(negedge sys_clk);
        stack_op = core_sfr_pkg::STK_NONE;
        rd(8'h81, 8'h21);
    endtask
    task t_dptr;
        wr(8'h82, 8'h34);
        wr(8'h83, 8'h12);
        chk("dptr", data_pointer, 16'h1234);
        wr(8'ha2, 8'hff);
        rd(8'ha2, 8'h01);
        chk("address_pointer_one", data_pointer, 16'h0000);
        @(negedge sys_clk);
        dptr_word = 16'hbeef;
        dptr_word_wr = 1;
        @(negedge sys_clk);
        dptr_word_wr = 0;
        rd(8'h83, 8'hbe);
        wr(8'ha2, 8'h00);
        chk("address_pointer_zero", data_pointer, 16'h1234);
    endtask
    task t_pwr;
        wr(8'h87, 8'hff);
        rd(8'h87, 8'h02);
        chk("sleep", 16'(sleep_request), 16'h0001);
        @(negedge sys_clk);
        ext_irq_wake = 1;
        @(negedge sys_clk);
        ext_irq_wake = 0;
        rd(8'h87, 8'h00);
        wr(8'h85, 8'h5a);
        rd(8'h85, 8'h00);
        // a reset in mid-run clears the request and sets the stack pointer back to 0x07
        wr(8'h87, 8'h02);
        chk("sleep", 16'(sleep_request), 16'h0001);
        @(negedge sys_clk);
        rst = 1;
        repeat (2) @(negedge sys_clk);
        rst = 0;
        rd(8'h87, 8'h00);
        rd(8'h81, 8'h07);
    endtask
    // main sequence
    initial
    begin
        repeat (16) @(negedge sys_clk);
        rst = 0;
        t_reset;
        t_arith;
        t_psw;
        t_stack;
        t_dptr;
        t_pwr;
        stop_test;
    end
endmodule
